// File: hw/scps_consts.vh
// constants for the stepper configuration pin and standby block
`ifndef SCPS_CONSTS_VH
`define SCPS_CONSTS_VH

// register byte offsets
`define SCPS_ADDR_GLOBAL_CONFIG     8'h00
`define SCPS_ADDR_HOLD      8'h04
`define SCPS_ADDR_STATUS    8'h08
`define SCPS_ADDR_CFG       8'h0c

// global_config field positions
`define SCPS_GC_PDN_IGNORE  0
`define SCPS_GC_PINS_OFF    1
`define SCPS_GC_SW_FAST     2
`define SCPS_GC_AUTO_SW     3

// reset values
`define SCPS_GLOBAL_CONFIG_RST      4'h0
`define SCPS_HOLD_RST       5'h10
`define SCPS_CFG_RST        3'h0

// microstep encodings (log2 of microsteps)
`define SCPS_MRES_8         3'h3
`define SCPS_MRES_16        3'h4
`define SCPS_MRES_32        3'h5
`define SCPS_MRES_64        3'h6

// synchroniser depth
`define SCPS_SYNC_STAGES    2

`endif

// File: hw/scps_sync.v
// two-flop level synchroniser for one pin
`timescale 1ns/1ns
module scps_sync (
    input  wire clk_in,
    input  wire resetn_in,
    input  wire ce_in,
    input  wire rst_val_in,
    input  wire d_in,
    output wire q_out
);
    reg meta_r;
    reg q_r;

    // first stage feeds only the second stage
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_r <= rst_val_in;                  // safe idle level, so no false change follows reset
            q_r    <= rst_val_in;
        end else if (ce_in) begin
            meta_r <= d_in;
            q_r    <= meta_r;
        end
    end

    assign q_out = q_r;
endmodule // scps_sync

// File: hw/scps_ahb.v
// ahb-lite slave front end: captures address phase, yields one-cycle strobes
`timescale 1ns/1ns
module scps_ahb (
    input  wire        clk_in,
    input  wire        resetn_in,
    input  wire        ce_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire        hready_in,
    output wire        wr_out,
    output wire        rd_out,
    output wire [7:0]  addr_out
);
    reg       wr_r;
    reg       rd_r;
    reg [7:0] addr_r;

    // zero wait states: data phase is always the cycle after the address phase
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_r   <= 1'b0;
            rd_r   <= 1'b0;
            addr_r <= 8'h00;
        end else if (ce_in) begin
            wr_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
            rd_r <= hsel_in && hready_in && htrans_in[1] && !hwrite_in;
            if (hsel_in && hready_in && htrans_in[1]) begin
                addr_r <= haddr_in[7:0];
            end
        end
    end

    assign wr_out   = wr_r;
    assign rd_out   = rd_r;
    assign addr_out = addr_r;
endmodule // scps_ahb

// File: hw/scps_top.v
// configuration pin decode and standby control for a stepper driver
// How it works
// RQ1: power-down pin low enables standstill current reduction; high disables it
// RQ2: host sets pin ignore flag; then hold current register governs standstill
// RQ3: software may disable config pins so register settings take precedence
// RQ4: microstep pins hi,lo: 00=8, 01=32, 10=64, 11=16 microsteps
// RQ5: chopper pin low selects quiet chopper; high selects fast-decay chopper
// RQ6: optional programmed auto switch to fast chopper above a step rate
// RQ7: standby input high turns off regulator and all internal units
// RQ8: leaving standby restores all registers to power-up defaults
// RQ9: controller stops motor before asserting standby
// RQ10: controller holds driver disable low during standby
// RQ11: driver disable high switches off power stage, outputs float
// RQ12: all configuration and standby pins are synchronised before use; step_fast_in is used without synchronisation
`timescale 1ns/1ns
`include "scps_consts.vh"
module scps_top (
    input  wire        clk_in,
    input  wire        resetn_in,
    input  wire        ce_in,
    // configuration and standby pins
    input  wire        power_down_n_pin_in,
    input  wire        microstep_sel_lo_in,
    input  wire        microstep_sel_hi_in,
    input  wire        chopper_select_pin_in,
    input  wire        standby_in,
    input  wire        driver_disable_n_in,
    input  wire        step_fast_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    // decoded settings
    output reg         auto_power_down_out,
    output reg  [4:0]  hold_current_out,
    output reg  [2:0]  microstep_res_out,
    output reg         fast_chopper_out,
    output reg         power_stage_on_out,
    output reg         regulator_on_out,
    output reg         standby_active_out
);
    // run, then standby while the pin is high, then one wake cycle, then run
    localparam ST_RUN     = 3'b001;
    localparam ST_STANDBY = 3'b010;
    localparam ST_WAKE    = 3'b100;

    // synchronised pin levels and bus strobes
    wire       pdn_s;
    wire       ms_lo_s;
    wire       ms_hi_s;
    wire       chop_s;
    wire       stby_s;
    wire       dis_s;
    wire       wr_w;
    wire       rd_w;
    wire [7:0] addr_w;

    // standby state, software registers and decode results
    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [3:0] global_config_r;
    reg  [4:0] hold_current_r;
    reg  [2:0] cfg_mres_r;
    reg  [2:0] pin_mres;
    reg  [2:0] mres_sel;
    reg        pdn_sel;
    reg        fast_sel;
    wire       units_on;
    wire       soft_rst;
    // legal register resolution and status word
    reg  [2:0] cfg_mres_legal;
    wire [31:0] status_w;

    // every pin except step_fast_in crosses two flops before decode [RQ12]
    // one instance per pin keeps the stages identical
    // power-down pin resets to its idle high level, so no reduction flashes on after reset
    scps_sync u_sync_pdn (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .rst_val_in (1'b1),
        .d_in       (power_down_n_pin_in),
        .q_out      (pdn_s)
    );

    scps_sync u_sync_mlo (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .rst_val_in (1'b0),
        .d_in       (microstep_sel_lo_in),
        .q_out      (ms_lo_s)
    );

    scps_sync u_sync_mhi (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .rst_val_in (1'b0),
        .d_in       (microstep_sel_hi_in),
        .q_out      (ms_hi_s)
    );

    scps_sync u_sync_chp (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .rst_val_in (1'b0),
        .d_in       (chopper_select_pin_in),
        .q_out      (chop_s)
    );

    scps_sync u_sync_sby (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .rst_val_in (1'b0),
        .d_in       (standby_in),
        .q_out      (stby_s)
    );

    // disable pin resets as asserted: the stage stays off until the pin is really seen low
    scps_sync u_sync_dis (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .rst_val_in (1'b1),
        .d_in       (driver_disable_n_in),
        .q_out      (dis_s)
    );

    // bus address and data phase capture
    scps_ahb u_ahb (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .hsel_in   (hsel_in),
        .haddr_in  (haddr_in),
        .htrans_in (htrans_in),
        .hwrite_in (hwrite_in),
        .hready_in (hready_in),
        .wr_out    (wr_w),
        .rd_out    (rd_w),
        .addr_out  (addr_w)
    );

    // standby sequencing: wake state spends one cycle restoring defaults
    always @* begin
        case (state_r)
            ST_RUN:     state_nxt = stby_s ? ST_STANDBY : ST_RUN;       // [RQ7]
            ST_STANDBY: state_nxt = stby_s ? ST_STANDBY : ST_WAKE;
            ST_WAKE:    state_nxt = ST_RUN;                             // [RQ8]
            default:    state_nxt = ST_RUN;
        endcase
    end

    // state register, frozen with the clock enable
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= ST_RUN;
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    // units run only in the run state
    assign units_on = (state_r == ST_RUN);
    // registers also clear while in standby and on the wake cycle
    assign soft_rst = !units_on;                                        // [RQ8]

    // register writes; units in standby ignore the bus
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            global_config_r <= `SCPS_GLOBAL_CONFIG_RST;
            hold_current_r  <= `SCPS_HOLD_RST;
            cfg_mres_r      <= `SCPS_CFG_RST;
        end else if (ce_in) begin
            if (soft_rst) begin
                global_config_r <= `SCPS_GLOBAL_CONFIG_RST;                     // [RQ8]
                hold_current_r  <= `SCPS_HOLD_RST;
                cfg_mres_r      <= `SCPS_CFG_RST;
            end else if (wr_w) begin
                case (addr_w)
                    `SCPS_ADDR_GLOBAL_CONFIG: global_config_r <= hwdata_in[3:0];
                    `SCPS_ADDR_HOLD:  hold_current_r  <= hwdata_in[4:0];
                    `SCPS_ADDR_CFG:   cfg_mres_r      <= hwdata_in[2:0];
                    default:          hold_current_r  <= hold_current_r;
                endcase
            end
        end
    end

    // register resolution limited to the four legal codes; anything else falls back to 8
    always @* begin
        case (cfg_mres_r)
            `SCPS_MRES_16: cfg_mres_legal = `SCPS_MRES_16;
            `SCPS_MRES_32: cfg_mres_legal = `SCPS_MRES_32;
            `SCPS_MRES_64: cfg_mres_legal = `SCPS_MRES_64;
            default:       cfg_mres_legal = `SCPS_MRES_8;
        endcase
    end

    // microstep pin decode
    always @* begin
        case ({ms_hi_s, ms_lo_s})                                       // [RQ4]
            2'b00:   pin_mres = `SCPS_MRES_8;
            2'b01:   pin_mres = `SCPS_MRES_32;
            2'b10:   pin_mres = `SCPS_MRES_64;
            default: pin_mres = `SCPS_MRES_16;
        endcase
    end

    // register value overrides pins once pins are disabled
    always @* begin
        if (global_config_r[`SCPS_GC_PINS_OFF]) begin
            mres_sel = cfg_mres_legal;                                  // [RQ3]
            fast_sel = global_config_r[`SCPS_GC_SW_FAST];
        end else begin
            mres_sel = pin_mres;
            // high pin: fast decay; low or open: quiet, with optional auto switch
            fast_sel = chop_s ||
                (global_config_r[`SCPS_GC_AUTO_SW] && step_fast_in);    // [RQ5] [RQ6]
        end
    end

    // ignore flag drops the pin; reduction then uses hold current register
    always @* begin
        if (global_config_r[`SCPS_GC_PDN_IGNORE]) begin
            pdn_sel = 1'b1;                                             // [RQ2]
        end else begin
            pdn_sel = !pdn_s;                                           // [RQ1]
        end
    end

    // registered outputs
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            auto_power_down_out <= 1'b0;
            hold_current_out    <= `SCPS_HOLD_RST;
            microstep_res_out   <= `SCPS_MRES_8;
            fast_chopper_out    <= 1'b0;
            power_stage_on_out  <= 1'b0;
            regulator_on_out    <= 1'b1;
            standby_active_out  <= 1'b0;
        end else if (ce_in) begin
            auto_power_down_out <= units_on && pdn_sel;
            hold_current_out    <= hold_current_r;                      // [RQ2]
            microstep_res_out   <= mres_sel;
            fast_chopper_out    <= fast_sel;
            // disable pin high floats outputs; standby also stops the stage
            power_stage_on_out  <= units_on && !dis_s;                  // [RQ11]
            regulator_on_out    <= !stby_s;                             // [RQ7]
            // flag looks one state ahead so it changes together with the regulator
            standby_active_out  <= (state_nxt == ST_STANDBY);           // [RQ7]
        end
    end

    // status word: synchronised pin levels and the settings in force
    assign status_w = {22'h000000,
                       dis_s,
                       chop_s,
                       ms_hi_s,
                       ms_lo_s,
                       pdn_s,
                       stby_s,
                       fast_sel,
                       mres_sel};

    // read data; zero wait states, always okay
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else if (ce_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            // decoded in the address phase, so the word stands through the data phase
            if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
                case (haddr_in[7:0])
                    `SCPS_ADDR_GLOBAL_CONFIG:  hrdata_out <= {28'h0000000, global_config_r};
                    `SCPS_ADDR_HOLD:   hrdata_out <= {27'h0000000, hold_current_r};
                    `SCPS_ADDR_CFG:    hrdata_out <= {29'h00000000, cfg_mres_r};
                    `SCPS_ADDR_STATUS: hrdata_out <= status_w;
                    default:           hrdata_out <= 32'h0000_0000;
                endcase
            end else if (rd_w) begin
                hrdata_out <= hrdata_out;
            end
        end
    end
endmodule // scps_top

// File: sim/scps_checker.sv
// concurrent checks on the config pin and standby block ports
`timescale 1ns/1ns
`include "scps_consts.vh"
module scps_checker (
    input wire       clk_in,
    input wire       resetn_in,
    input wire       ce_in,
    input wire       power_down_n_pin_in,
    input wire       standby_in,
    input wire       driver_disable_n_in,
    input wire       hreadyout_out,
    input wire       hresp_out,
    input wire       auto_power_down_out,
    input wire [4:0] hold_current_out,
    input wire [2:0] microstep_res_out,
    input wire       power_stage_on_out,
    input wire       regulator_on_out,
    input wire       standby_active_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // pins need three stable samples to reach the settled outputs
    AST_READY: assert property (hreadyout_out && !hresp_out) else $error("bus wait or error seen");
    AST_STBY: assert property ((ce_in && standby_in)[*3] |=> standby_active_out) else $error("no standby");
    AST_WAKE: assert property ((ce_in && !standby_in)[*4] |=> !standby_active_out && regulator_on_out)
        else $error("no wake");
    AST_OFF: assert property (standby_active_out |-> !regulator_on_out) else $error("regulator on in standby");
    AST_DEF: assert property ($fell(standby_active_out) |-> hold_current_out == `SCPS_HOLD_RST)
        else $error("hold not default after standby");
    AST_PSTAGE: assert property ((ce_in && driver_disable_n_in)[*3] |=> !power_stage_on_out)
        else $error("power stage on while disabled");
    AST_PDN: assert property ((ce_in && !power_down_n_pin_in && !standby_in)[*5] ##1 !standby_active_out
        |-> auto_power_down_out) else $error("no standstill reduction");
    AST_MRES: assert property (microstep_res_out inside {`SCPS_MRES_8, `SCPS_MRES_16, `SCPS_MRES_32,
        `SCPS_MRES_64}) else $error("bad microstep code");
    AST_SYNC: assert property ($rose(standby_active_out) |-> $past(standby_in, 3))
        else $error("standby taken before sync");
endmodule // scps_checker

bind scps_top scps_checker u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .power_down_n_pin_in(power_down_n_pin_in), .standby_in(standby_in), .driver_disable_n_in(driver_disable_n_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .auto_power_down_out(auto_power_down_out),
    .hold_current_out(hold_current_out), .microstep_res_out(microstep_res_out),
    .power_stage_on_out(power_stage_on_out), .regulator_on_out(regulator_on_out),
    .standby_active_out(standby_active_out));

// File: sim/scps_pin_host.sv
// board host model that drives the strapping and standby pins
`timescale 1ns/1ns
module scps_pin_host (
    input  wire       clk_in,
    input  wire [5:0] req_in,
    output reg        power_down_n_pin_out,
    output reg        microstep_sel_lo_out,
    output reg        microstep_sel_hi_out,
    output reg        chopper_select_pin_out,
    output reg        driver_disable_n_out,
    output reg        standby_out
);
    // req_in is {sleep, disable_n, chopper, ms_hi, ms_lo, pdn_n}; no step pulses are ever issued here,
    // so the motor is at standstill whenever sleep is asked
    always @(posedge clk_in) begin
        {standby_out, driver_disable_n_out, chopper_select_pin_out} <= req_in[5:3];
        {microstep_sel_hi_out, microstep_sel_lo_out, power_down_n_pin_out} <= req_in[2:0];
        if (req_in[5]) begin
            driver_disable_n_out <= 1'b0; // disable input held low while asleep
        end
    end
endmodule // scps_pin_host

// File: sim/scps_top_test.sv
// self-checking bench for the config pin and standby block
`timescale 1ns/1ns
`include "scps_consts.vh"
module scps_top_test;
    reg         clk_in = 1'b0;
    reg         resetn_in = 1'b0;
    reg  [5:0]  req = 6'h01;
    reg         step_fast = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg  [31:0] rd;
    reg  [11:0] mres_tbl = {`SCPS_MRES_16, `SCPS_MRES_64, `SCPS_MRES_32, `SCPS_MRES_8};
    wire [31:0] hrdata;
    wire        hready, pdn_n, ms_lo, ms_hi, chop, sleep, dis_n, auto_pd, fast, pstage, reg_on, stby;
    wire [4:0]  hold;
    wire [2:0]  mres;
    integer     n_fail = 0;
    integer     total_checks = 0;
    integer     i;

    scps_pin_host u_host (.clk_in(clk_in), .req_in(req), .power_down_n_pin_out(pdn_n),
        .microstep_sel_lo_out(ms_lo), .microstep_sel_hi_out(ms_hi), .chopper_select_pin_out(chop),
        .driver_disable_n_out(dis_n), .standby_out(sleep));
    scps_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .power_down_n_pin_in(pdn_n),
        .microstep_sel_lo_in(ms_lo), .microstep_sel_hi_in(ms_hi), .chopper_select_pin_in(chop),
        .standby_in(sleep), .driver_disable_n_in(dis_n), .step_fast_in(step_fast), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .auto_power_down_out(auto_pd), .hold_current_out(hold), .microstep_res_out(mres),
        .fast_chopper_out(fast), .power_stage_on_out(pstage), .regulator_on_out(reg_on),
        .standby_active_out(stby));

    // free-running 100 MHz clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // one single-word transfer; each phase is held until hready is sampled high
    task xfer(input wr, input [7:0] a, input [31:0] wd);
        begin
            @(posedge clk_in);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= wr;
            haddr <= {24'h0, a};
            do @(posedge clk_in); while (hready !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            do @(posedge clk_in); while (hready !== 1'b1);
            rd = hrdata;
        end
    endtask

    // pins need host flop plus two sync flops plus output register
    task settle;
        repeat (6) @(posedge clk_in);
    endtask

    task test_done;
        begin
            $display("checks=%0d failures=%0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // hang guard, far beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        n_fail = n_fail + 1;
        test_done;
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        xfer(1'b0, `SCPS_ADDR_HOLD, 32'h0);
        chk(rd, 32'h10);
        xfer(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            req <= {3'b000, i[1:0], 1'b1};
            settle;
            chk(mres, mres_tbl[i*3 +: 3]);
        end
        for (i = 0; i < 2; i = i + 1) begin
            req <= {1'b0, i[0], i[0], 2'b00, ~i[0]};
            settle;
            chk(fast, i[0]);
            chk(auto_pd, i[0]);
            chk(pstage, !i[0]);
        end
        req <= 6'h01; // chopper pin low, power-down pin high
        xfer(1'b1, `SCPS_ADDR_GLOBAL_CONFIG, 32'h8);
        step_fast <= 1'b1;
        settle;
        chk(fast, 1'b1);
        step_fast <= 1'b0;
        settle;
        chk(fast, 1'b0);
        chk(auto_pd, 1'b0);
        xfer(1'b1, `SCPS_ADDR_GLOBAL_CONFIG, 32'h1);
        xfer(1'b1, `SCPS_ADDR_HOLD, 32'h5);
        settle;
        chk(auto_pd, 1'b1);
        chk(hold, 5'h05);
        xfer(1'b1, `SCPS_ADDR_CFG, 32'h6);
        xfer(1'b1, `SCPS_ADDR_GLOBAL_CONFIG, 32'h6);
        settle;
        chk(mres, `SCPS_MRES_64);
        chk(fast, 1'b1);
        xfer(1'b0, `SCPS_ADDR_GLOBAL_CONFIG, 32'h0);
        chk(rd, 32'h6);
        req <= 6'h21;
        settle;
        chk(reg_on, 1'b0);
        chk(stby, 1'b1);
        xfer(1'b1, `SCPS_ADDR_HOLD, 32'h3);
        req <= 6'h01;
        settle;
        xfer(1'b0, `SCPS_ADDR_HOLD, 32'h0);
        chk(rd, 32'h10);
        xfer(1'b0, `SCPS_ADDR_GLOBAL_CONFIG, 32'h0);
        chk(rd, 32'h0);
        chk(mres, `SCPS_MRES_8);
        chk(reg_on, 1'b1);
        chk(stby, 1'b0);
        test_done;
    end
endmodule // scps_top_test
